// file: hdl/dbopw_pkg.sv
// Shared constants and types for the dual-bridge off-time PWM controller
package dbopw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_LEVEL = 8'h0C;
  localparam logic [18:1] DATA_RST = 18'h00000;
  localparam logic [18:1] CTRL_RST = 18'h00000;

  // ----------------------------------------------------------------
  // Data word fields (bit n holds Dn)
  // ----------------------------------------------------------------
  localparam int DAC_LSB_B1 = 1;
  localparam int BRIDGE_STRIDE = 8;
  localparam int DAC_W = 6;
  localparam int PHASE_OFS = 6;
  localparam int MODE_OFS = 7;
  localparam int RANGE_LSB = 17;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int BLANK_LSB = 1;
  localparam int OFF_LSB = 3;
  localparam int OFF_W = 5;
  localparam int FD_LSB = 8;
  localparam int FD_W = 4;

  // ----------------------------------------------------------------
  // Timing tables in master clock periods, and the range gain table
  // ----------------------------------------------------------------
  localparam logic [3:0] BLANK_CYC [4] = '{4'h4, 4'h6, 4'h8, 4'hC};
  localparam logic [5:0] OFF_EXTRA = 6'h01;
  localparam logic [4:0] GAIN_TAB [4] = '{5'h08, 5'h0C, 5'h10, 5'h14};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {B_IDLE, B_TURNON, B_BLANK, B_ON, B_DECAY} dbopw_bstate_t;

  typedef struct packed {
    logic hi;
    logic lo;
  } dbopw_leg_t;

  typedef struct packed {
    dbopw_bstate_t state;
    logic phase;
    logic [5:0] el;
  } dbopw_bridge_t;

  typedef struct packed {
    logic gh;
    logic gl;
    logic [2:0] dh;
    logic [2:0] dl;
  } dbopw_dt_t;

  typedef struct packed {
    logic [6:0] level;
    logic [4:0] gain;
  } dbopw_trip_t;

endpackage

// file: hdl/dbopw_leg_dt.sv
// One bridge leg: gate pair with dead time before any complementary turn-on
`timescale 1ns/1ps
`default_nettype none
module dbopw_leg_dt (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requested and actual gate state
  input wire dbopw_pkg::dbopw_leg_t want,
  input wire logic [2:0] dead_cyc,
  output dbopw_pkg::dbopw_leg_t drive
);
  import dbopw_pkg::*;

  dbopw_dt_t s_q;
  dbopw_dt_t s_d;

  // ----------------------------------------------------------------
  // Dead-time counters and gate decisions
  // ----------------------------------------------------------------
  // Turn-off is immediate; turn-on waits for the partner's dead count
  always_comb begin
    s_d = s_q;
    s_d.dh = s_q.gl ? dead_cyc : ((s_q.dh != 3'h0) ? 3'(s_q.dh - 3'h1) : 3'h0);
    s_d.dl = s_q.gh ? dead_cyc : ((s_q.dl != 3'h0) ? 3'(s_q.dl - 3'h1) : 3'h0);
    s_d.gh = want.hi & ~want.lo & ~s_q.gl & (s_q.dh == 3'h0);
    s_d.gl = want.lo & ~want.hi & ~s_q.gh & (s_q.dl == 3'h0);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Registered gate drive
  assign drive = {s_q.gh, s_q.gl};

endmodule
`default_nettype wire

// file: hdl/dbopw_trip_level.sv
// Per-bridge current trip reference: DAC step and range gain
`timescale 1ns/1ps
`default_nettype none
module dbopw_trip_level (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Programmed fields
  input wire logic [5:0] dac_code,
  input wire logic [1:0] range_sel,
  // Reference for the external comparator
  output dbopw_pkg::dbopw_trip_t trip
);
  import dbopw_pkg::*;

  dbopw_trip_t s_q;
  dbopw_trip_t s_d;

  // ----------------------------------------------------------------
  // Level in steps of Vref/64 and gain from the range table
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.level = (dac_code == 6'h00) ? 7'h00 : 7'({1'b0, dac_code} + 7'h01);
    s_d.gain = GAIN_TAB[range_sel];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trip = s_q;

endmodule
`default_nettype wire

// file: hdl/dbopw_top.sv
// Dual-bridge fixed off-time PWM current controller with APB registers
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dbopw_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Gate disable and current-sense comparators
  input wire logic disable_in,
  input wire logic [1:0] cmp_trip,
  // Gate drives, index 2*bridge+leg, leg A=0 and B=1
  output logic [3:0] high_side_gate_out,
  output logic [3:0] low_side_gate_out,
  // Comparator reference per bridge
  output dbopw_pkg::dbopw_trip_t [1:0] trip_ref
);
  import dbopw_pkg::*;

  typedef struct packed {
    logic [18:1] data;
    logic [18:1] ctrl;
    logic [31:0] prdata;
    dbopw_bridge_t [1:0] br;
    logic [3:0] gh;
    logic [3:0] gl;
  } dbopw_top_t;

  dbopw_top_t s_q;
  dbopw_top_t s_d;

  logic [1:0][5:0] code_w;
  logic [1:0] ph_w;
  logic [1:0] mode_w;
  logic [3:0] blank_w;
  logic [2:0] dead_w;
  logic [5:0] off_w;
  logic [3:0] fd_w;
  dbopw_leg_t [3:0] want;
  dbopw_leg_t leg_drv [4];
  dbopw_trip_t trip_w [2];
  logic [31:0] status_w;
  logic [31:0] level_w;
  logic addr_ok;

  // ----------------------------------------------------------------
  // Field decode from the data and control words
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_fields
      // Per-bridge fields sit one stride apart
      assign code_w[g] = s_q.data[DAC_LSB_B1 + g * BRIDGE_STRIDE +: DAC_W];
      assign ph_w[g] = s_q.data[DAC_LSB_B1 + g * BRIDGE_STRIDE + PHASE_OFS];
      assign mode_w[g] = s_q.data[DAC_LSB_B1 + g * BRIDGE_STRIDE + MODE_OFS];
    end
  endgenerate

  // Shared timing settings, counted in clock periods
  assign blank_w = BLANK_CYC[s_q.ctrl[BLANK_LSB +: 2]];
  assign dead_w = blank_w[3:1];
  assign off_w = 6'({1'b0, s_q.ctrl[OFF_LSB +: OFF_W]} + OFF_EXTRA);
  assign fd_w = s_q.ctrl[FD_LSB +: FD_W];

  // ----------------------------------------------------------------
  // APB decode and readback
  // ----------------------------------------------------------------
  assign addr_ok = (paddr == ADDR_DATA) || (paddr == ADDR_CTRL) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_LEVEL);
  assign status_w = {16'h0000, s_q.gl, s_q.gh, 1'b0, s_q.br[1].state,
                     1'b0, s_q.br[0].state};
  assign level_w = {8'h00, trip_ref[1], trip_ref[0]};
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = s_q.prdata;

  // ----------------------------------------------------------------
  // Next state: registers, bridge sequencers, gate outputs
  // ----------------------------------------------------------------
  always_comb begin
    logic on_ph;
    logic decay;
    logic fast;
    logic src_on;
    logic snk_on;
    logic cur_src;
    s_d = s_q;
    on_ph = 1'b0;
    decay = 1'b0;
    fast = 1'b0;
    src_on = 1'b0;
    snk_on = 1'b0;
    cur_src = 1'b0;
    want = '0;
    // Read data captured in the setup phase for the access phase
    if (psel && !penable) begin
      case (paddr)
        ADDR_DATA: s_d.prdata = {13'h0000, s_q.data, 1'b0};
        ADDR_CTRL: s_d.prdata = {13'h0000, s_q.ctrl, 1'b0};
        ADDR_STATUS: s_d.prdata = status_w;
        ADDR_LEVEL: s_d.prdata = level_w;
        default: s_d.prdata = 32'h00000000;
      endcase
    end
    // Writes land at the access edge; disable has no say here
    if (psel && penable && pwrite) begin
      case (paddr)
        ADDR_DATA: s_d.data = pwdata[18:1];
        ADDR_CTRL: s_d.ctrl = pwdata[18:1];
        default: ;
      endcase
    end
    // Two sequencers, each reading its own fields and state plus the shared timing settings
    for (int i = 0; i < 2; i++) begin
      // Gate wishes from the present state and latched direction
      on_ph = (s_q.br[i].state == B_TURNON) || (s_q.br[i].state == B_BLANK) ||
              (s_q.br[i].state == B_ON);
      decay = (s_q.br[i].state == B_DECAY);
      fast = decay & ~mode_w[i] & (s_q.br[i].el < {2'b00, fd_w});
      src_on = on_ph;
      snk_on = on_ph | (decay & ~fast);
      // Direction one: A high, B low; zero: B high, A low
      want[2 * i].hi = src_on & s_q.br[i].phase;
      want[2 * i + 1].hi = src_on & ~s_q.br[i].phase;
      want[2 * i].lo = snk_on & ~s_q.br[i].phase;
      want[2 * i + 1].lo = snk_on & s_q.br[i].phase;
      cur_src = s_q.br[i].phase ? leg_drv[2 * i].hi : leg_drv[2 * i + 1].hi;
      // Sequencer step
      case (s_q.br[i].state)
        B_IDLE: begin
          if (code_w[i] != 6'h00) begin
            s_d.br[i].state = B_TURNON;
          end
        end
        B_TURNON: begin
          // Blank starts once the source gate is really on
          if (cur_src) begin
            s_d.br[i].state = B_BLANK;
            s_d.br[i].el = 6'h01;
          end
        end
        B_BLANK: begin
          // Comparator not looked at while blanking
          if (s_q.br[i].el >= {2'b00, blank_w}) begin
            s_d.br[i].state = B_ON;
          end else begin
            s_d.br[i].el = 6'(s_q.br[i].el + 6'h01);
          end
        end
        B_ON: begin
          if (cmp_trip[i]) begin
            s_d.br[i].state = B_DECAY;
            s_d.br[i].el = 6'h00;
          end
        end
        B_DECAY: begin
          // Off-time counted from the trip edge, then a new on-phase
          if (s_q.br[i].el >= 6'(off_w - 6'h01)) begin
            s_d.br[i].state = B_TURNON;
            s_d.br[i].el = 6'h00;
          end else begin
            s_d.br[i].el = 6'(s_q.br[i].el + 6'h01);
          end
        end
        default: begin
          s_d.br[i].state = B_IDLE;
          s_d.br[i].el = 6'h00;
        end
      endcase
      // Direction change restarts the on-phase and blank count
      if (ph_w[i] != s_q.br[i].phase) begin
        s_d.br[i].phase = ph_w[i];
        s_d.br[i].state = B_TURNON;
        s_d.br[i].el = 6'h00;
      end
      // Code zero holds the bridge idle with every driver off
      if (code_w[i] == 6'h00) begin
        s_d.br[i].state = B_IDLE;
        s_d.br[i].el = 6'h00;
      end
    end
    // Disable only masks the pins; one means FET on
    for (int k = 0; k < 4; k++) begin
      s_d.gh[k] = leg_drv[k].hi & ~disable_in;
      s_d.gl[k] = leg_drv[k].lo & ~disable_in;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.data <= DATA_RST;
      s_q.ctrl <= CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign high_side_gate_out = s_q.gh;
  assign low_side_gate_out = s_q.gl;

  // ----------------------------------------------------------------
  // Legs with dead time, and trip references
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < 4; g++) begin : g_leg
      // One dead-time stage per leg
      dbopw_leg_dt u_leg (
        .pclk(pclk),
        .presetn(presetn),
        .want(want[g]),
        .dead_cyc(dead_w),
        .drive(leg_drv[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_trip
      // Reference per bridge from its own code; the range field is shared by both
      dbopw_trip_level u_trip (
        .pclk(pclk),
        .presetn(presetn),
        .dac_code(code_w[g]),
        .range_sel(s_q.data[RANGE_LSB +: 2]),
        .trip(trip_w[g])
      );
    end
  endgenerate

  // Both references leave through one packed port, driven once
  assign trip_ref = {trip_w[1], trip_w[0]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_disable_gates_off: assert property (@(posedge pclk) disable iff (!presetn)
    disable_in |=> (high_side_gate_out == 4'h0) && (low_side_gate_out == 4'h0))
    else $error("gate on one cycle after disable");

  generate
    for (g = 0; g < 4; g++) begin : g_leg_chk
      a_leg_no_shoot: assert property (@(posedge pclk) disable iff (!presetn)
        !(high_side_gate_out[g] && low_side_gate_out[g]))
        else $error("both gates of a leg on");
      a_dead_min_gap: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(low_side_gate_out[g]) |-> !high_side_gate_out[g] [*2])
        else $error("high gate on inside dead time");
    end
    for (g = 0; g < 2; g++) begin : g_br_chk
      a_code_zero_off: assert property (@(posedge pclk) disable iff (!presetn)
        (code_w[g] == 6'h00) [*4] |->
          (high_side_gate_out[2 * g +: 2] == 2'b00) && (low_side_gate_out[2 * g +: 2] == 2'b00))
        else $error("gate on with zero current code");
      a_blank_no_trip: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.br[g].state == B_BLANK) |=> (s_q.br[g].state != B_DECAY))
        else $error("trip taken during blank");
      a_trip_to_decay: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.br[g].state == B_ON) && cmp_trip[g] && (code_w[g] != 6'h00) &&
          (ph_w[g] == s_q.br[g].phase) |=> (s_q.br[g].state == B_DECAY))
        else $error("trip did not start decay");
      a_phase_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (ph_w[g] != s_q.br[g].phase) && (code_w[g] != 6'h00) |=>
          (s_q.br[g].state == B_TURNON) && (s_q.br[g].el == 6'h00))
        else $error("direction change did not restart");
      a_decay_src_off: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.br[g].state == B_DECAY) [*3] |->
          !high_side_gate_out[2 * g + (s_q.br[g].phase ? 0 : 1)])
        else $error("source gate on during decay");
      a_off_time_end: assert property (@(posedge pclk) disable iff (!presetn)
        (s_q.br[g].state == B_DECAY) && (s_q.br[g].el == 6'(off_w - 6'h01)) &&
          (code_w[g] != 6'h00) && (ph_w[g] == s_q.br[g].phase) |=>
          (s_q.br[g].state == B_TURNON))
        else $error("off-time end missed");
    end
  endgenerate

endmodule
`default_nettype wire

// file: testbench/dbopw_load_model.sv
// Winding current and sense comparator model for both bridges
`timescale 1ns/1ps
`default_nettype none
module dbopw_load_model (
  // Clock
  input wire logic pclk,
  // Gate drives and trip reference
  input wire logic [3:0] gh,
  input wire logic [3:0] gl,
  input wire dbopw_pkg::dbopw_trip_t [1:0] trip_ref,
  input wire logic [1:0] stuck,
  // Comparator outputs and cross-conduction flag
  output logic [1:0] cmp_trip,
  output logic shoot
);
  import dbopw_pkg::*;
  int cur [2] = '{0, 0};
  logic shoot_q = 1'b0;
  assign shoot = shoot_q;
  // Current rises on a driven diagonal and falls otherwise
  always @(posedge pclk) begin
    for (int b = 0; b < 2; b++) begin
      if ((gh[2*b] && gl[2*b+1]) || (gh[2*b+1] && gl[2*b])) begin
        cur[b] <= cur[b] + 1;
      end else if (cur[b] > 0) begin
        cur[b] <= cur[b] - 1;
      end
    end
    if ((gh & gl) != 4'h0) begin
      shoot_q <= 1'b1;
    end
  end
  // Comparator trips once the current reaches the reference level
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      cmp_trip[b] = stuck[b] || (cur[b] >= int'(trip_ref[b].level));
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the dual-bridge off-time PWM controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dbopw_pkg::*;
  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic disable_in = 1'b0;
  logic [1:0] cmp_trip;
  logic [1:0] stuck = 2'h0;
  logic [3:0] gh;
  logic [3:0] gl;
  logic [3:0] gh_p = 4'h0;
  logic [3:0] gl_p = 4'h0;
  logic shoot;
  dbopw_trip_t [1:0] trip_ref;
  logic [31:0] lf = 32'hB54D;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int guard = 0;
  int m_data = 0;
  int m_ctrl = 0;
  int off_t [8] = '{default: -1000};
  int n;
  int c0;
  int c1;
  int f;

  always #5 pclk = ~pclk;

  dbopw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .disable_in(disable_in), .cmp_trip(cmp_trip),
    .high_side_gate_out(gh), .low_side_gate_out(gl), .trip_ref(trip_ref));

  dbopw_load_model load (.pclk(pclk), .gh(gh), .gl(gl), .trip_ref(trip_ref),
    .stuck(stuck), .cmp_trip(cmp_trip), .shoot(shoot));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task check(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] dw(input int a0, p0, m0, a1, p1, m1, r);
    return (a0 << 1) | (p0 << 7) | (m0 << 8) | (a1 << 9) | (p1 << 15) | (m1 << 16) | (r << 17);
  endfunction

  function automatic logic [31:0] cw(input int bl, off, fd);
    return (bl << 1) | (off << 3) | (fd << 8);
  endfunction

  // Expected reference: zero for code 0, else code+1 with gain 8/12/16/20
  function automatic dbopw_trip_t exp_t(input int c, input int r);
    exp_t.level = (c == 0) ? 7'h00 : 7'(c + 1);
    exp_t.gain = 5'(8 + 4 * r);
  endfunction

  // One APB transfer: setup, then access until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50) check(1'b0, "bus wait timed out");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == ADDR_DATA) m_data = d & 32'h0007FFFE;
    if (a == ADDR_CTRL) m_ctrl = d & 32'h0007FFFE;
  endtask

  task setup(input logic [31:0] c, input logic [31:0] d);
    wr(ADDR_DATA, 32'h00000000);
    wr(ADDR_CTRL, c);
    wr(ADDR_DATA, d);
  endtask

  // Count edges until a gate shows the wanted level
  task wait_g(input bit lo, input int i, input logic v);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (((lo ? gl[i] : gh[i]) !== v) && n < 400);
    check(n < 400, "gate wait timed out");
  endtask

  // Dead-time monitor on every leg, paused around disable
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    guard <= disable_in ? 8 : (guard > 0 ? guard - 1 : 0);
    for (int i = 0; i < 4; i++) begin
      if (gh_p[i] && !gh[i]) off_t[i] <= cyc;
      if (gl_p[i] && !gl[i]) off_t[i+4] <= cyc;
      if (gh[i] && !gh_p[i] && guard == 0) check(cyc - off_t[i+4] >= BLANK_CYC[m_ctrl[2:1]] / 2, "dead high");
      if (gl[i] && !gl_p[i] && guard == 0) check(cyc - off_t[i] >= BLANK_CYC[m_ctrl[2:1]] / 2, "dead low");
    end
    gh_p <= gh;
    gl_p <= gl;
  end

  // Watchdog
  initial begin
    #500000;
    num_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check(gh === 4'h0 && gl === 4'h0 && trip_ref === 24'h000000, "reset outputs");
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd === 32'h00000000, "ctrl reset");
    // Register access, unused bits and unmapped address
    wr(ADDR_CTRL, 32'hFFFFFFFF);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd === m_ctrl, "ctrl readback");
    apb(1'b1, 8'h10, 32'h1);
    check(er === 1'b1, "unmapped write error");
    apb(1'b0, 8'h10, 32'h0);
    check(rd === 32'h0 && er === 1'b1, "unmapped read");
    // Trip reference for random codes in every range
    for (int r = 0; r < 4; r++) begin
      lf = lfsr(lfsr(lf));
      c0 = (r == 0) ? 0 : int'(lf[5:0]);
      c1 = int'(lf[13:8]);
      wr(ADDR_DATA, dw(c0, 0, 1, c1, 0, 1, r));
      apb(1'b0, ADDR_LEVEL, 32'h0);
      check(trip_ref[0] === exp_t(c0, r) && trip_ref[1] === exp_t(c1, r), "trip ref");
      check(rd[23:0] === {exp_t(c1, r), exp_t(c0, r)}, "level read");
      apb(1'b0, ADDR_DATA, 32'h0);
      check(rd === m_data, "data readback");
    end
    // Diagonal pair per direction and bridge, other bridge idle
    for (int b = 0; b < 2; b++) begin
      for (int p = 0; p < 2; p++) begin
        setup(cw(0, 3, 0), b == 0 ? dw(20, p, 1, 0, 0, 1, 0) : dw(0, 0, 1, 20, p, 1, 0));
        wait_g(1'b1, 2 * b + p, 1'b1);
        wait_g(1'b0, 2 * b + 1 - p, 1'b1);
        check(((gh | gl) & (b == 0 ? 4'hC : 4'h3)) === 4'h0, "idle bridge");
      end
    end
    // Off time for field values 0, 7 and 31
    for (int k = 0; k < 3; k++) begin
      f = (k == 0) ? 0 : (k == 1) ? 7 : 31;
      setup(cw(0, f, 0), dw(30, 1, 1, 0, 0, 1, 0));
      wait_g(1'b0, 0, 1'b1);
      wait_g(1'b0, 0, 1'b0);
      wait_g(1'b0, 0, 1'b1);
      check(n >= f + 1 && n <= f + 2, "off time");
    end
    // Blank time with the comparator held high, then a phase change
    @(posedge pclk);
    stuck <= 2'h1;
    for (int k = 0; k < 4; k++) begin
      setup(cw(k, 4, 0), dw(30, 1, 1, 0, 0, 1, 0));
      wait_g(1'b0, 0, 1'b1);
      wait_g(1'b0, 0, 1'b0);
      check(n >= BLANK_CYC[k] && n <= BLANK_CYC[k] + 4, "blank time");
    end
    wait_g(1'b0, 0, 1'b1);
    wr(ADDR_DATA, dw(30, 0, 1, 0, 0, 1, 0));
    wait_g(1'b0, 1, 1'b1);
    wait_g(1'b0, 1, 1'b0);
    check(n >= BLANK_CYC[3], "blank after phase change");
    @(posedge pclk);
    stuck <= 2'h0;
    // Slow, fast and mixed decay after a trip
    for (int k = 0; k < 3; k++) begin
      setup(cw(0, 20, k == 2 ? 6 : 15), dw(30, 1, k == 0, 0, 0, 1, 0));
      wait_g(1'b0, 0, 1'b1);
      wait_g(1'b0, 0, 1'b0);
      repeat (3) @(posedge pclk);
      check(gl[1] === (k == 0), "decay sink early");
      repeat (9) @(posedge pclk);
      check(gl[1] === (k != 1), "decay sink late");
    end
    // Disable masks the gates while registers and sequencing run on
    setup(cw(1, 6, 0), dw(30, 1, 0, 25, 0, 0, 2));
    wait_g(1'b0, 0, 1'b1);
    @(posedge pclk);
    disable_in <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 40; k++) begin
      @(posedge pclk);
      check(gh === 4'h0 && gl === 4'h0, "gates while disabled");
    end
    wr(ADDR_CTRL, cw(1, 6, 0));
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd === m_ctrl, "ctrl write while disabled");
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[2:0] !== 3'h0 && rd[6:4] !== 3'h0, "sequencer while disabled");
    disable_in <= 1'b0;
    wait_g(1'b0, 0, 1'b1);
    check(shoot === 1'b0, "cross-conduction");
    finish_test();
  end
endmodule
`default_nettype wire
